// ==== core/flp_map.vh ====
/*
 * Offsets, field positions, reset values and codes of the flash programming
 * control register bank.
 * Assumes a 32-bit AHB-Lite slave that decodes the low byte of the address.
 */
`ifndef FLP_MAP_VH
`define FLP_MAP_VH

// Byte offsets of the registers within the bank.
`define FLP_CTRL_OFS 8'h00
`define FLP_KEY_OFS 8'h10
`define FLP_TADDR_OFS 8'h20
`define FLP_WORD_OFS 8'h30
`define FLP_SRC_OFS 8'h40
`define FLP_IRQ_STAT_OFS 8'h50
`define FLP_IRQ_MASK_OFS 8'h54

// Distance of the clear, set and invert companions above their base register.
`define FLP_ALIAS_CLR 2'h1
`define FLP_ALIAS_SET 2'h2
`define FLP_ALIAS_INV 2'h3
`define FLP_ALIAS_BASE 2'h0

// Field positions in the program control register.
`define FLP_BIT_TRIG 15
`define FLP_BIT_GATE 14
`define FLP_BIT_FAIL 13
`define FLP_BIT_LVF 12
`define FLP_BIT_LVA 11
`define FLP_OP_HI 3
`define FLP_OP_LO 0

// Bits that software may change, per register.
`define FLP_CTRL_WMASK 32'h0000_c00f
`define FLP_TADDR_WMASK 32'hffff_fffc

// Reset values.
`define FLP_CTRL_RST 32'h0000_0000
`define FLP_REG_RST 32'h0000_0000

// Operation selector codes.
`define FLP_OP_NONE 4'h0
`define FLP_OP_WORD 4'h1
`define FLP_OP_ROW 4'h3
`define FLP_OP_PAGE 4'h4
`define FLP_OP_FULL 4'h5

// Unlock key pair; the values are arbitrary.
`define FLP_KEY_FIRST 32'h1234_5678
`define FLP_KEY_SECOND 32'h8765_4321

// Interrupt status and mask layout.
`define FLP_IRQ_W 3
`define FLP_IRQ_DONE 0
`define FLP_IRQ_FAIL 1
`define FLP_IRQ_LVF 2

`endif

// ==== core/flp_sync.v ====
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes inputs come from outside the clk_in domain; output follows only
 * once the second and third stages agree.
 */
module flp_sync #(
   parameter WIDTH = 1
) (
   input wire clk_in,
   input wire rst_in,
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] level_out
);

   genvar i;

   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg s1_q;
         reg s2_q;
         reg s3_q;
         reg out_q;

         // The first stage feeds only the second, so metastability stays contained.
         always @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
               out_q <= 1'b0;
            end else begin
               s1_q <= async_in[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  out_q <= s3_q;
               end
            end
         end

         assign level_out[i] = out_q;
      end
   endgenerate

endmodule // flp_sync

// ==== core/flp_regs.v ====
/*
 * Flash self-programming control register bank with AHB-Lite slave access,
 * unlock sequencing, operation launch and interrupt status.
 * Assumes a flash array controller that takes a start pulse with the code,
 * address and data, and answers with a one-cycle done pulse on clk_in.
 * The low-voltage detector output arrives asynchronously.
 */
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`include "flp_map.vh"

// Summary of operation
// - Seven registers: control, unlock key, target address, program word, source address, interrupt status, interrupt mask.
// - Clear companion at +0x4 clears writable bits written as one.
// - Set companion at +0x8 sets writable bits written as one.
// - Invert companion at +0xC toggles writable bits written as one.
// - Unimplemented bits read zero and ignore writes.
// - Trigger writable only with write gate and unlock; hardware clears it when done.
// - Reset clears write gate; gate enables trigger writes and low-voltage detector.
// - Codes 1,3,4,5 start operations; 0,2,6 start no flash operation; others reserved.
// - Fail and low-voltage flags are hardware set, cleared by starting code zero.
module flp_regs (
   input wire clk_in,
   input wire rst_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output wire hreadyout_out,
   output wire hresp_out,
   output wire [31:0] hrdata_out,
   output wire op_start_out,
   output wire [3:0] op_code_out,
   output wire [31:0] op_addr_out,
   output wire [31:0] op_word_out,
   output wire [31:0] op_src_out,
   output wire lvd_enable_out,
   output wire irq_out,
   input wire op_done_in,
   input wire op_fail_in,
   input wire low_voltage_in
);

   localparam ST_IDLE = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_END = 3'b100;

   localparam SEL_CTRL = 3'd0;
   localparam SEL_TADDR = 3'd1;
   localparam SEL_WORD = 3'd2;
   localparam SEL_SRC = 3'd3;
   localparam SEL_KEY = 3'd4;
   localparam SEL_STAT = 3'd5;
   localparam SEL_MASK = 3'd6;
   localparam SEL_NONE = 3'd7;

   localparam RD_IDLE = 2'd0;
   localparam RD_WAIT = 2'd1;
   localparam RD_READY = 2'd2;

   // Which register a byte offset hits; companions map to their base.
   function [2:0] reg_sel;
      input [7:0] off;
      begin
         if (off[1:0] != 2'b00) begin
            reg_sel = SEL_NONE;
         end else if ({off[7:4], 4'h0} == `FLP_CTRL_OFS) begin
            reg_sel = SEL_CTRL; // Companions share the base's sixteen-byte slot.
         end else if ({off[7:4], 4'h0} == `FLP_TADDR_OFS) begin
            reg_sel = SEL_TADDR;
         end else if (off == `FLP_KEY_OFS) begin
            reg_sel = SEL_KEY;
         end else if (off == `FLP_WORD_OFS) begin
            reg_sel = SEL_WORD;
         end else if (off == `FLP_SRC_OFS) begin
            reg_sel = SEL_SRC;
         end else if (off == `FLP_IRQ_STAT_OFS) begin
            reg_sel = SEL_STAT;
         end else if (off == `FLP_IRQ_MASK_OFS) begin
            reg_sel = SEL_MASK;
         end else begin
            reg_sel = SEL_NONE;
         end
      end
   endfunction

   // Merge a write into a register through the base or a companion alias.
   function [31:0] alias_merge;
      input [31:0] old;
      input [31:0] wdata;
      input [1:0] kind;
      input [31:0] wmask;
      reg [31:0] hit;
      begin
         hit = wdata & wmask;
         case (kind)
            `FLP_ALIAS_CLR: alias_merge = old & ~hit;
            `FLP_ALIAS_SET: alias_merge = old | hit;
            `FLP_ALIAS_INV: alias_merge = old ^ hit;
            default: alias_merge = (old & ~wmask) | hit;
         endcase
      end
   endfunction

   reg [31:0] taddr_q;
   reg [31:0] word_q;
   reg [31:0] src_q;
   reg [3:0] op_q;
   reg trig_q;
   reg gate_q;
   reg fail_q;
   reg lvf_q;
   reg [1:0] key_stage_q;
   reg [2:0] st_q;
   reg start_q;
   reg [`FLP_IRQ_W-1:0] irq_stat_q;
   reg [`FLP_IRQ_W-1:0] irq_mask_q;
   reg wr_pend_q;
   reg [7:0] addr_q;
   reg [1:0] rd_stage_q;
   reg [31:0] hrdata_q;

   wire lv_level;
   wire aphase;
   wire wr_now;
   wire [2:0] wr_sel;
   wire [1:0] wr_kind;
   wire [31:0] ctrl_view;
   wire [31:0] ctrl_new;
   wire trig_req;
   wire launch;
   wire real_op;
   wire clear_errs;
   wire set_fail;
   wire set_lvf;
   wire op_done_evt;
   reg [31:0] rd_mux;

   // The detector output is asynchronous to the bus clock.
   flp_sync #(
      .WIDTH(1)
   ) u_lv_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .async_in(low_voltage_in),
      .level_out(lv_level)
   );

   // Single transfers only; a read costs one wait state so data comes from a flop.
   assign aphase = hsel_in & hready_in & htrans_in[1];
   assign hreadyout_out = (rd_stage_q != RD_WAIT);
   assign hresp_out = 1'b0;
   assign hrdata_out = hrdata_q;

   // Address phase capture and read wait state sequencing.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
         rd_stage_q <= RD_IDLE;
      end else begin
         if (hready_in) begin
            wr_pend_q <= aphase & hwrite_in;
            if (aphase) begin
               addr_q <= haddr_in[7:0];
            end
         end
         if (rd_stage_q == RD_WAIT) begin
            rd_stage_q <= RD_READY;
         end else if (aphase && !hwrite_in) begin
            rd_stage_q <= RD_WAIT;
         end else begin
            rd_stage_q <= RD_IDLE;
         end
      end
   end

   assign wr_now = wr_pend_q;
   assign wr_sel = reg_sel(addr_q);
   assign wr_kind = (wr_sel == SEL_CTRL || wr_sel == SEL_TADDR) ? addr_q[3:2] :
      `FLP_ALIAS_BASE;

   // Read-only status bits are placed in the view but masked out of every write.
   assign ctrl_view = {16'h0000, trig_q, gate_q, fail_q, lvf_q, lv_level & gate_q, 7'h00,
      op_q};
   assign ctrl_new = alias_merge(ctrl_view, hwdata_in, wr_kind, `FLP_CTRL_WMASK);

   // Trigger only takes a one while gated and unlocked; software cannot drop it.
   assign trig_req = wr_now && wr_sel == SEL_CTRL && ctrl_new[`FLP_BIT_TRIG] && !trig_q &&
      gate_q && key_stage_q == 2'd2;
   assign launch = trig_req;

   // Unlock sequence: first key then second key, consumed by any control write.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         key_stage_q <= 2'd0;
      end else if (wr_now && wr_sel == SEL_KEY) begin
         if (hwdata_in == `FLP_KEY_FIRST) begin
            key_stage_q <= 2'd1;
         end else if (key_stage_q == 2'd1 && hwdata_in == `FLP_KEY_SECOND) begin
            key_stage_q <= 2'd2;
         end else begin
            key_stage_q <= 2'd0;
         end
      end else if (wr_now && wr_sel == SEL_CTRL) begin
         key_stage_q <= 2'd0;
      end
   end

   assign real_op = (op_q == `FLP_OP_WORD) || (op_q == `FLP_OP_ROW) ||
      (op_q == `FLP_OP_PAGE) || (op_q == `FLP_OP_FULL);
   assign clear_errs = launch && op_q == `FLP_OP_NONE;
   assign set_fail = (st_q == ST_RUN) && op_done_in && op_fail_in;
   assign set_lvf = (st_q == ST_RUN) && gate_q && lv_level;
   assign op_done_evt = (st_q == ST_END);

   // Operation sequencer; no-operation and reserved codes finish at once.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= ST_IDLE;
         start_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (launch) begin
                  if (real_op) begin
                     st_q <= ST_RUN;
                     start_q <= 1'b1;
                  end else begin
                     st_q <= ST_END;
                  end
               end
            end
            ST_RUN: begin
               if (op_done_in) begin
                  st_q <= ST_END;
               end
            end
            ST_END: begin
               st_q <= ST_IDLE;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Control register; hardware events win over a simultaneous software write.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         gate_q <= 1'b0;
         trig_q <= 1'b0;
         op_q <= `FLP_OP_NONE;
         fail_q <= 1'b0;
         lvf_q <= 1'b0;
      end else begin
         if (wr_now && wr_sel == SEL_CTRL) begin
            gate_q <= ctrl_new[`FLP_BIT_GATE];
            if (!gate_q) begin
               op_q <= ctrl_new[`FLP_OP_HI:`FLP_OP_LO];
            end
         end
         if (op_done_evt) begin
            trig_q <= 1'b0;
         end else if (launch) begin
            trig_q <= 1'b1;
         end
         if (set_fail) begin
            fail_q <= 1'b1;
         end else if (clear_errs) begin
            fail_q <= 1'b0;
         end
         if (set_lvf) begin
            lvf_q <= 1'b1;
         end else if (clear_errs) begin
            lvf_q <= 1'b0;
         end
      end
   end

   // Address and data registers; the address keeps its two low bits at zero.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         taddr_q <= `FLP_REG_RST;
         word_q <= `FLP_REG_RST;
         src_q <= `FLP_REG_RST;
      end else if (wr_now) begin
         if (wr_sel == SEL_TADDR) begin
            taddr_q <= alias_merge(taddr_q, hwdata_in, wr_kind, `FLP_TADDR_WMASK);
         end
         if (wr_sel == SEL_WORD) begin
            word_q <= hwdata_in;
         end
         if (wr_sel == SEL_SRC) begin
            src_q <= hwdata_in;
         end
      end
   end

   // Sticky interrupt flags cleared by writing one; a new event beats the clear.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_stat_q <= {`FLP_IRQ_W{1'b0}};
         irq_mask_q <= {`FLP_IRQ_W{1'b0}};
      end else begin
         if (wr_now && wr_sel == SEL_MASK) begin
            irq_mask_q <= hwdata_in[`FLP_IRQ_W-1:0];
         end
         if (wr_now && wr_sel == SEL_STAT) begin
            irq_stat_q <= irq_stat_q & ~hwdata_in[`FLP_IRQ_W-1:0] |
               {set_lvf, set_fail, op_done_evt};
         end else begin
            irq_stat_q <= irq_stat_q | {set_lvf, set_fail, op_done_evt};
         end
      end
   end

   assign irq_out = |(irq_stat_q & irq_mask_q);

   // Read view; the key and all companions read as zero.
   always @* begin
      rd_mux = 32'h0000_0000;
      case (reg_sel(addr_q))
         SEL_CTRL: rd_mux = (addr_q[3:2] == `FLP_ALIAS_BASE) ? ctrl_view : 32'h0000_0000;
         SEL_TADDR: rd_mux = (addr_q[3:2] == `FLP_ALIAS_BASE) ? taddr_q : 32'h0000_0000;
         SEL_WORD: rd_mux = word_q;
         SEL_SRC: rd_mux = src_q;
         SEL_STAT: rd_mux = {29'h0000_0000, irq_stat_q};
         SEL_MASK: rd_mux = {29'h0000_0000, irq_mask_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data is loaded during the wait state, after any write before it landed.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         hrdata_q <= 32'h0000_0000;
      end else if (rd_stage_q == RD_WAIT) begin
         hrdata_q <= rd_mux;
      end
   end

   // Flash controller side; the detector runs while the write gate is set.
   assign op_start_out = start_q;
   assign op_code_out = op_q;
   assign op_addr_out = taddr_q;
   assign op_word_out = word_q;
   assign op_src_out = src_q;
   assign lvd_enable_out = gate_q;

endmodule // flp_regs

// ==== tb/flp_regs_checker.sv ====
/*
 * Port checker for the flash programming register bank.
 * Assumes it is bound to flp_regs, with hready_in fed from hreadyout_out.
 */
module flp_regs_checker (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic [31:0] hrdata_out,
   input wire logic op_start_out,
   input wire logic [3:0] op_code_out,
   input wire logic lvd_enable_out,
   input wire logic irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // An address phase the slave accepts.
   wire logic take = hsel_in && hready_in && htrans_in[1];
   wire logic [7:0] ofs = haddr_in[7:0];

   AST_OKAY: assert property (hresp_out == 1'b0) else $error("response not okay");
   AST_RD_WAIT: assert property (take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
      else $error("read wait state wrong");
   AST_WR_ZERO: assert property (take && hwrite_in |=> hreadyout_out)
      else $error("write stalled");
   AST_WAIT_CAUSE: assert property (!hreadyout_out |-> $past(take && !hwrite_in))
      else $error("stall without read");
   AST_ZERO_RD: assert property (take && !hwrite_in && ofs inside {8'h04, 8'h10, 8'h60}
      ##2 hreadyout_out |-> hrdata_out == 32'h0) else $error("read not zero");
   AST_GATE_SET: assert property ((take && hwrite_in && ofs == 8'h08) ##1 hwdata_in[14]
      |=> lvd_enable_out) else $error("gate not set");
   AST_GATE_CLR: assert property ((take && hwrite_in && ofs == 8'h04) ##1 hwdata_in[14]
      |=> !lvd_enable_out) else $error("gate not cleared");
   AST_PULSE: assert property (op_start_out |=> !op_start_out) else $error("start too long");
   AST_START_GATE: assert property (op_start_out |-> $past(lvd_enable_out))
      else $error("start without gate");
   AST_CODE_HOLD: assert property ($past(lvd_enable_out) |-> $stable(op_code_out))
      else $error("code changed under gate");

   // Main scenarios reached.
   COV_START: cover property (op_start_out);
   COV_IRQ: cover property ($rose(irq_out));
   COV_READ: cover property (take && !hwrite_in);
endmodule // flp_regs_checker

// ==== tb/flp_regs_tb.sv ====
/*
 * Self-checking testbench for the flash programming register bank.
 * Assumes the AHB-Lite slave is alone on the bus and the flash side is played here.
 */
`include "flp_map.vh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic hsel_in = 1'b0, hwrite_in = 1'b0, op_done_in = 1'b0, op_fail_in = 1'b0;
   logic low_voltage_in = 1'b0;
   logic [1:0] htrans_in = 2'h0;
   logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0;
   wire logic hready_in, hreadyout_out, hresp_out, irq_out, op_start_out, lvd_enable_out;
   wire logic [31:0] hrdata_out, op_addr_out, op_word_out, op_src_out;
   wire logic [3:0] op_code_out;
   logic rdy_s;
   logic [31:0] rd_s;
   logic [3:0] start_code;
   int errors = 0, total_checks = 0, starts = 0;

   assign hready_in = hreadyout_out;
   // Free-running 50 MHz clock.
   always #10 clk_in = ~clk_in;

   flp_regs dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
      .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2),
      .hwdata_in(hwdata_in), .hready_in(hready_in), .hreadyout_out(hreadyout_out),
      .hresp_out(hresp_out), .hrdata_out(hrdata_out), .op_start_out(op_start_out),
      .op_code_out(op_code_out), .op_addr_out(op_addr_out), .op_word_out(op_word_out),
      .op_src_out(op_src_out), .lvd_enable_out(lvd_enable_out), .irq_out(irq_out),
      .op_done_in(op_done_in), .op_fail_in(op_fail_in), .low_voltage_in(low_voltage_in));

   // Bus answers are sampled mid-cycle, so no race with the edge that moves them.
   always @(negedge clk_in) begin
      rdy_s = hreadyout_out;
      rd_s = hrdata_out;
   end

   // Count launches; the code is taken with each pulse.
   always @(posedge clk_in) begin
      if (op_start_out === 1'b1) begin
         starts++;
         start_code = op_code_out;
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits for hready at an edge; a slave that never answers is a mismatch.
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (rdy_s !== 1'b1 && n < 50);
      if (rdy_s !== 1'b1) check(32'h0, 32'h1);
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_in);
      hsel_in <= 1'b1;
      haddr_in <= {24'h0, a};
      htrans_in <= 2'h2;
      hwrite_in <= w;
      wait_rdy();
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= d;
      wait_rdy();
      q = rd_s;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask

   task automatic t_reset;
      logic [7:0] offs [7] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h54};
      foreach (offs[i]) rd(offs[i], 32'h0);
      check({31'h0, lvd_enable_out}, 32'h0);
   endtask

   task automatic t_data;
      wr(8'h20, 32'hffff_ffff);
      rd(8'h20, 32'hffff_fffc);
      wr(8'h24, 32'hf0f0_0000);
      rd(8'h20, 32'h0f0f_fffc);
      wr(8'h28, 32'h3000_0003);
      rd(8'h20, 32'h3f0f_fffc);
      wr(8'h2c, 32'hffff_0000);
      rd(8'h20, 32'hc0f0_fffc);
      check(op_addr_out, 32'hc0f0_fffc);
      wr(8'h30, 32'ha5a5_5a5a);
      rd(8'h30, 32'ha5a5_5a5a);
      check(op_word_out, 32'ha5a5_5a5a);
      wr(8'h40, 32'h0123_4567);
      rd(8'h40, 32'h0123_4567);
      check(op_src_out, 32'h0123_4567);
      wr(8'h10, 32'hffff_ffff);
      rd(8'h10, 32'h0);
      wr(8'h60, 32'hffff_ffff);
      rd(8'h60, 32'h0);
   endtask

   task automatic t_ctrl;
      // Unlocked, but the gate is still clear before this write, so the trigger is refused.
      wr(8'h10, `FLP_KEY_FIRST);
      wr(8'h10, `FLP_KEY_SECOND);
      wr(8'h00, 32'h0000_ffff);
      rd(8'h00, 32'h0000_400f);
      check({31'h0, lvd_enable_out}, 32'h1);
      wr(8'h04, 32'h0000_4000);
      rd(8'h00, 32'h0000_000f);
      wr(8'h0c, 32'h0000_000a);
      rd(8'h00, 32'h0000_0005);
      wr(8'h08, 32'h0000_3802);
      rd(8'h00, 32'h0000_0007);
      wr(8'h04, 32'h0000_0007);
      rd(8'h00, 32'h0);
   endtask

   // Full launch: gate off, code, gate on, unlock, trigger; flash answers only when a start is expected.
   task automatic run_op(input logic [3:0] code, input logic fail, input int exp);
      int n;
      wr(8'h04, 32'h0000_4000);
      wr(8'h00, {28'h0, code});
      wr(8'h08, 32'h0000_4000);
      wr(8'h10, `FLP_KEY_FIRST);
      wr(8'h10, `FLP_KEY_SECOND);
      n = starts;
      wr(8'h08, 32'h0000_8000);
      repeat (3) @(posedge clk_in);
      check(starts, n + exp);
      if (exp == 1) begin
         check({28'h0, start_code}, {28'h0, code});
         rd(8'h00, 32'h0000_c000 | code | (low_voltage_in ? 32'h1800 : 32'h0));
         @(posedge clk_in);
         op_done_in <= 1'b1;
         op_fail_in <= fail;
         @(posedge clk_in);
         op_done_in <= 1'b0;
         op_fail_in <= 1'b0;
         repeat (3) @(posedge clk_in);
      end
   endtask

   task automatic t_ops;
      logic [3:0] codes [8] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h0, 4'h2, 4'h6, 4'hf};
      foreach (codes[i]) begin
         run_op(codes[i], 1'b0, (codes[i] inside {4'h1, 4'h3, 4'h4, 4'h5}) ? 1 : 0);
         rd(8'h00, 32'h0000_4000 | codes[i]);
      end
      wr(8'h08, 32'h0000_8000);
      repeat (3) @(posedge clk_in);
      rd(8'h00, 32'h0000_400f);
   endtask

   task automatic t_irq;
      rd(8'h50, 32'h1);
      wr(8'h54, 32'h1);
      @(negedge clk_in);
      check({31'h0, irq_out}, 32'h1);
      wr(8'h50, 32'h1);
      @(negedge clk_in);
      check({31'h0, irq_out}, 32'h0);
      wr(8'h54, 32'h0);
   endtask

   task automatic t_fail;
      @(posedge clk_in);
      low_voltage_in <= 1'b1;
      repeat (6) @(posedge clk_in);
      run_op(4'h1, 1'b1, 1);
      rd(8'h00, 32'h0000_7801);
      rd(8'h50, 32'h7);
      low_voltage_in <= 1'b0;
      repeat (6) @(posedge clk_in);
      rd(8'h00, 32'h0000_7001);
      run_op(4'h0, 1'b0, 0);
      rd(8'h00, 32'h0000_4000);
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Main sequence after a five-cycle reset.
   initial begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      t_reset();
      t_data();
      t_ctrl();
      t_ops();
      t_irq();
      t_fail();
      summarize();
   end

   // Watchdog: the whole run needs a few thousand cycles at most.
   initial begin
      #200000;
      errors++;
      $display("Error at %0t: got %h expected %h", $time, 32'h0, 32'h1);
      summarize();
   end
endmodule // testbench

bind flp_regs flp_regs_checker u_chk (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
   .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
   .hready_in(hready_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
   .hrdata_out(hrdata_out), .op_start_out(op_start_out), .op_code_out(op_code_out),
   .lvd_enable_out(lvd_enable_out), .irq_out(irq_out));
